// ===== verilog/hub_port_power_role_ctrl.v
// What this block does
// [R1] Enabled port: power pin released as input with pull-up, enabling power.
// [R2] Enabled port: low on its power pin is an overcurrent for it.
// [R3] Disabled port, by configuration or host: power pin driven low, in ganged mode only when all ports are disabled.
// [R4] Ganged mode: shared power pin is the power pin for all ports.
// [R5] Role-swap request low: port 0 upstream, port 1 downstream.
// [R6] Role-swap request high: port 0 downstream, port 1 upstream.
// [R7] Role-swap indicator shows 0 default, 1 swapped.
// [R8] ROM enabled: chip select held high in power-down.
// [R9] ROM disable bit set: serial clock pin becomes spare I/O four.
// [R10] ROM enabled: serial clock held low throughout reset.
// [R11] Data pins carry ROM traffic only when ROM enabled, else released.
// [R12] Board terminates unused ROM pins per their alternate functions.
// [R13] Each attach input 1 powers its SuperSpeed PHY, 0 powers it off.
// [R14] Legacy connector boards tie all attach inputs high.
// [R15] Role, attach, shared power and sense inputs pass two flip-flops.
`timescale 1ns/1ps
`include "hub_port_ctrl_regs.vh"

module hub_port_power_role_ctrl #(
   parameter NPORT   = 7,
   parameter NATTACH = 4
) (
   input  wire               ref_clk,
   input  wire               rst_n,
   input  wire               clkEn,
   input  wire [7:0]         s_axi_awaddr,
   input  wire               s_axi_awvalid,
   output reg                s_axi_awready,
   input  wire [31:0]        s_axi_wdata,
   input  wire [3:0]         s_axi_wstrb,
   input  wire               s_axi_wvalid,
   output reg                s_axi_wready,
   output reg  [1:0]         s_axi_bresp,
   output reg                s_axi_bvalid,
   input  wire               s_axi_bready,
   input  wire [7:0]         s_axi_araddr,
   input  wire               s_axi_arvalid,
   output reg                s_axi_arready,
   output reg  [31:0]        s_axi_rdata,
   output reg  [1:0]         s_axi_rresp,
   output reg                s_axi_rvalid,
   input  wire               s_axi_rready,
   output reg                irq_r,
   input  wire [NPORT-1:0]   portPowerSensePin,
   output reg  [NPORT-1:0]   portPowerOut_r,
   output reg  [NPORT-1:0]   portPowerOe_r,
   output reg  [NPORT-1:0]   portPullupEn_r,
   input  wire               sharedPowerPin,
   output reg                sharedPowerOut_r,
   output reg                sharedPowerOe_r,
   output reg                sharedPullupEn_r,
   input  wire               roleSwapRequest,
   output reg                roleSwapIndicator_r,
   output reg                port0Upstream_r,
   output reg                port1Upstream_r,
   input  wire [NATTACH-1:0] typecAttachIn,
   output reg  [NATTACH-1:0] phyPowerOn_r,
   input  wire               romEngChipSelN,
   input  wire               romEngClk,
   input  wire               romEngDataOut,
   output reg                romEngDataIn_r,
   output reg                romChipSelN_r,
   input  wire               romClkPin,
   output reg                romClkOut_r,
   output reg                romClkOe_r,
   output reg                romDataOut_r,
   output reg                romDataOe_r,
   input  wire               romDataInPin
);

   // ----------------------------------------------------------------
   // Pin synchronisers.
   // ----------------------------------------------------------------
   localparam SW = NPORT + NATTACH + 4;

   wire [SW-1:0]      syncAll;
   wire [NPORT-1:0]   senseSync;
   wire [NATTACH-1:0] attachSync;
   wire               sharedSync;
   wire               roleSync;
   wire               clkPinSync;
   wire               dataInSync;

   pin_sync2 #(
      .WIDTH (SW)
   ) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clkEn   (clkEn),
      .asyncIn ({romDataInPin, romClkPin, roleSwapRequest, sharedPowerPin,
                 typecAttachIn, portPowerSensePin}),
      .syncOut (syncAll)
   ); // [R15]

   assign senseSync  = syncAll[NPORT-1:0];
   assign attachSync = syncAll[NPORT+NATTACH-1:NPORT];
   assign sharedSync = syncAll[NPORT+NATTACH];
   assign roleSync   = syncAll[NPORT+NATTACH+1];
   assign clkPinSync = syncAll[NPORT+NATTACH+2];
   assign dataInSync = syncAll[NPORT+NATTACH+3];

   // ----------------------------------------------------------------
   // Register state.
   // ----------------------------------------------------------------
   reg  [2:0]         ctrl_r;
   reg  [NPORT-1:0]   portCfgEn_r;
   reg  [NPORT-1:0]   portHostEn_r;
   reg  [11:0]        intStat_r;
   reg  [11:0]        intMask_r;
   reg  [1:0]         spareIo_r;
   reg  [NPORT-1:0]   ocPrev_r;
   reg  [NATTACH-1:0] attachPrev_r;
   reg                rolePrev_r;
   reg  [7:0]         awAddr_r;
   reg  [31:0]        wData_r;
   reg  [3:0]         wStrb_r;
   reg                awHeld_r;
   reg                wHeld_r;

   wire ganged  = ctrl_r[`CTRL_GANGED];
   wire romEn   = ~ctrl_r[`CTRL_ROM_DIS];
   wire pwrDown = ctrl_r[`CTRL_PWR_DOWN];

   // ----------------------------------------------------------------
   // Per-port power and overcurrent.
   // ----------------------------------------------------------------
   wire [NPORT-1:0] portOn;
   wire [NPORT-1:0] ocNow;
   wire [NPORT-1:0] pinOe_nxt;
   wire [NPORT-1:0] pinPu_nxt;

   genvar gi;
   generate
      for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_port
         assign portOn[gi]    = portCfgEn_r[gi] & portHostEn_r[gi];
         assign pinPu_nxt[gi] = ~ganged & portOn[gi]; // [R1]
         assign pinOe_nxt[gi] = ~ganged & ~portOn[gi]; // [R3]
         assign ocNow[gi]     = portOn[gi] & ~(ganged ? sharedSync : senseSync[gi]); // [R2] [R4]
      end
   endgenerate

   wire anyOn = |portOn;

   // ----------------------------------------------------------------
   // Interrupt events.
   // ----------------------------------------------------------------
   wire [11:0] evSet = {attachSync ^ attachPrev_r, roleSync ^ rolePrev_r, ocNow & ~ocPrev_r};

   // ----------------------------------------------------------------
   // Bus write decode.
   // ----------------------------------------------------------------
   wire [31:0] wMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
   wire [31:0] wVal  = wData_r & wMask;
   wire        doWr  = awHeld_r & wHeld_r & ~s_axi_bvalid;
   wire        wrHit = (awAddr_r == `OFS_CTRL) || (awAddr_r == `OFS_PORT_CFG_EN) ||
                       (awAddr_r == `OFS_PORT_HOST) || (awAddr_r == `OFS_STATUS) ||
                       (awAddr_r == `OFS_INT_STAT) || (awAddr_r == `OFS_INT_MASK) ||
                       (awAddr_r == `OFS_SPARE_IO);

   reg [11:0] w1c;

   always @* begin
      w1c = 12'h000;
      if (doWr && awAddr_r == `OFS_INT_STAT) begin
         w1c = wVal[11:0];
      end
   end

   // ----------------------------------------------------------------
   // Bus read decode.
   // ----------------------------------------------------------------
   reg [31:0] rdVal;
   reg        rdHit;

   always @* begin
      rdVal = 32'h0000_0000;
      rdHit = 1'b1;
      case (s_axi_araddr)
         `OFS_CTRL: begin
            rdVal[2:0] = ctrl_r;
         end
         `OFS_PORT_CFG_EN: begin
            rdVal[NPORT-1:0] = portCfgEn_r;
         end
         `OFS_PORT_HOST: begin
            rdVal[NPORT-1:0] = portHostEn_r;
         end
         `OFS_STATUS: begin
            rdVal[NPORT-1:0] = ocPrev_r;
            rdVal[`ST_ROLE] = roleSwapIndicator_r;
            rdVal[`ST_ATTACH_LSB+NATTACH-1:`ST_ATTACH_LSB] = phyPowerOn_r;
            rdVal[`ST_SPARE_IN] = clkPinSync;
            rdVal[`ST_DATA_IN] = dataInSync;
         end
         `OFS_INT_STAT: begin
            rdVal[11:0] = intStat_r;
         end
         `OFS_INT_MASK: begin
            rdVal[11:0] = intMask_r;
         end
         `OFS_SPARE_IO: begin
            rdVal[1:0] = spareIo_r;
         end
         default: begin
            rdHit = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Bus handshakes.
   // ----------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
         awHeld_r      <= 1'b0;
         wHeld_r       <= 1'b0;
         awAddr_r      <= 8'h00;
         wData_r       <= 32'h0000_0000;
         wStrb_r       <= 4'h0;
      end else if (clkEn) begin
         s_axi_awready <= ~awHeld_r & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~wHeld_r & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (doWr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdVal;
            s_axi_rresp  <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Software registers and interrupts.
   // ----------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r       <= `RST_CTRL;
         portCfgEn_r  <= `RST_PORT_EN;
         portHostEn_r <= `RST_PORT_EN;
         intMask_r    <= `RST_INT_MASK;
         spareIo_r    <= `RST_SPARE_IO;
         intStat_r    <= 12'h000;
         irq_r        <= 1'b0;
         ocPrev_r     <= {NPORT{1'b0}};
         attachPrev_r <= {NATTACH{1'b0}};
         rolePrev_r   <= 1'b0;
      end else if (clkEn) begin
         if (doWr) begin
            case (awAddr_r)
               `OFS_CTRL: begin
                  ctrl_r <= (ctrl_r & ~wMask[2:0]) | wVal[2:0];
               end
               `OFS_PORT_CFG_EN: begin
                  portCfgEn_r <= (portCfgEn_r & ~wMask[NPORT-1:0]) | wVal[NPORT-1:0];
               end
               `OFS_PORT_HOST: begin
                  portHostEn_r <= (portHostEn_r & ~wMask[NPORT-1:0]) | wVal[NPORT-1:0];
               end
               `OFS_INT_MASK: begin
                  intMask_r <= (intMask_r & ~wMask[11:0]) | wVal[11:0];
               end
               `OFS_SPARE_IO: begin
                  spareIo_r <= (spareIo_r & ~wMask[1:0]) | wVal[1:0];
               end
               default: begin
                  ctrl_r <= ctrl_r;
               end
            endcase
         end
         ocPrev_r     <= ocNow;
         attachPrev_r <= attachSync;
         rolePrev_r   <= roleSync;
         intStat_r    <= (intStat_r & ~w1c) | evSet;
         irq_r        <= |(((intStat_r & ~w1c) | evSet) & intMask_r);
      end
   end

   // ----------------------------------------------------------------
   // Pin drive.
   // ----------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         portPowerOut_r      <= {NPORT{1'b0}};
         portPowerOe_r       <= {NPORT{1'b1}};
         portPullupEn_r      <= {NPORT{1'b0}};
         sharedPowerOut_r    <= 1'b0;
         sharedPowerOe_r     <= 1'b0;
         sharedPullupEn_r    <= 1'b0;
         roleSwapIndicator_r <= 1'b0;
         port0Upstream_r     <= 1'b1;
         port1Upstream_r     <= 1'b0;
         phyPowerOn_r        <= {NATTACH{1'b0}};
         romChipSelN_r       <= 1'b1;
         romClkOut_r         <= 1'b0;
         romClkOe_r          <= 1'b1;
         romDataOut_r        <= 1'b0;
         romDataOe_r         <= 1'b0;
         romEngDataIn_r      <= 1'b0;
      end else if (clkEn) begin
         portPowerOut_r      <= {NPORT{1'b0}}; // [R3]
         portPowerOe_r       <= pinOe_nxt; // [R3]
         portPullupEn_r      <= pinPu_nxt; // [R1]
         sharedPowerOut_r    <= 1'b0;
         sharedPowerOe_r     <= ganged & ~anyOn; // [R4]
         sharedPullupEn_r    <= ganged & anyOn; // [R4]
         roleSwapIndicator_r <= roleSync; // [R7]
         port0Upstream_r     <= ~roleSync; // [R5]
         port1Upstream_r     <= roleSync; // [R6]
         phyPowerOn_r        <= attachSync; // [R13]
         romChipSelN_r       <= ~romEn | pwrDown | romEngChipSelN; // [R8]
         if (romEn) begin
            romClkOut_r <= ~pwrDown & romEngClk;
            romClkOe_r  <= 1'b1; // [R10]
         end else begin
            romClkOut_r <= spareIo_r[`SPARE_OUT]; // [R9]
            romClkOe_r  <= spareIo_r[`SPARE_OE]; // [R9]
         end
         romDataOut_r        <= romEn & romEngDataOut; // [R11]
         romDataOe_r         <= romEn; // [R11]
         romEngDataIn_r      <= romEn & dataInSync; // [R11]
      end
   end

endmodule

// ===== verilog/hub_port_ctrl_regs.vh
`ifndef HUB_PORT_CTRL_REGS_VH
`define HUB_PORT_CTRL_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_PORT_CFG_EN 8'h04
`define OFS_PORT_HOST   8'h08
`define OFS_STATUS      8'h0C
`define OFS_INT_STAT    8'h10
`define OFS_INT_MASK    8'h14
`define OFS_SPARE_IO    8'h18

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define CTRL_GANGED     0
`define CTRL_ROM_DIS    1
`define CTRL_PWR_DOWN   2
`define SPARE_OUT       0
`define SPARE_OE        1
`define ST_ROLE         7
`define ST_ATTACH_LSB   8
`define ST_SPARE_IN     12
`define ST_DATA_IN      13
`define INT_ROLE        7
`define INT_ATTACH_LSB  8

// ----------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------
`define RST_CTRL        3'h0
`define RST_PORT_EN     7'h7F
`define RST_INT_MASK    12'h000
`define RST_SPARE_IO    2'h0

// ----------------------------------------------------------------
// Bus answers.
// ----------------------------------------------------------------
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ===== verilog/pin_sync2.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Two-stage synchroniser for pin inputs.
// ----------------------------------------------------------------
module pin_sync2 #(
   parameter WIDTH = 1
) (
   input  wire             ref_clk,
   input  wire             rst_n,
   input  wire             clkEn,
   input  wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1_r;
   reg [WIDTH-1:0] stage2_r;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_r <= {WIDTH{1'b0}};
         stage2_r <= {WIDTH{1'b0}};
      end else if (clkEn) begin
         stage1_r <= asyncIn;
         stage2_r <= stage1_r;
      end
   end

   assign syncOut = stage2_r;

endmodule

// ===== testbench/hub_port_chk.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pin and bus checks.
// ----------------------------------------------------------------
module hub_port_chk #(
   parameter NPORT   = 7,
   parameter NATTACH = 4
) (
   input wire logic               ref_clk,
   input wire logic               rst_n,
   input wire logic               roleSwapRequest,
   input wire logic               roleSwapIndicator_r,
   input wire logic               port0Upstream_r,
   input wire logic               port1Upstream_r,
   input wire logic [NATTACH-1:0] typecAttachIn,
   input wire logic [NATTACH-1:0] phyPowerOn_r,
   input wire logic [NPORT-1:0]   portPowerOut_r,
   input wire logic [NPORT-1:0]   portPowerOe_r,
   input wire logic [NPORT-1:0]   portPullupEn_r,
   input wire logic               sharedPowerOe_r,
   input wire logic               sharedPullupEn_r,
   input wire logic               romEngChipSelN,
   input wire logic               romChipSelN_r,
   input wire logic               romClkOut_r,
   input wire logic               romClkOe_r,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic [1:0]         s_axi_bresp
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence swapHeld;
      $rose(roleSwapRequest) ##1 roleSwapRequest [*2];
   endsequence
   role_rise_a: assert property (swapHeld |=> roleSwapIndicator_r)
      else $error("indicator missed a swap");
   role_follow_a: assert property (roleSwapIndicator_r == $past(roleSwapRequest, 3))
      else $error("indicator lags request wrongly");
   role_ports_a: assert property (port1Upstream_r == roleSwapIndicator_r && port0Upstream_r != roleSwapIndicator_r)
      else $error("port roles disagree with indicator");
   phy_follow_a: assert property (phyPowerOn_r == $past(typecAttachIn, 3))
      else $error("phy power does not follow attach");
   port_drive_a: assert property (portPowerOut_r == 0 && (sharedPullupEn_r || sharedPowerOe_r
      || (portPowerOe_r ^ portPullupEn_r) == {NPORT{1'b1}}))
      else $error("port pin neither pulled up nor driven low");
   gang_release_a: assert property ((sharedPullupEn_r || sharedPowerOe_r) |-> !(sharedPullupEn_r && sharedPowerOe_r)
      && portPowerOe_r == 0 && portPullupEn_r == 0)
      else $error("ganged mode pins wrong");
   csel_cause_a: assert property (!romChipSelN_r |-> !$past(romEngChipSelN))
      else $error("chip select low without request");
   clk_reset_a: assert property (@(posedge ref_clk) disable iff (1'b0) !rst_n ##1 !rst_n |-> !romClkOut_r && romClkOe_r)
      else $error("serial clock not low in reset");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
endmodule
bind hub_port_power_role_ctrl hub_port_chk #(.NPORT(NPORT), .NATTACH(NATTACH)) chk (.*);

// ===== testbench/hub_pin_partner.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Power switches, current monitors and serial ROM.
// ----------------------------------------------------------------
module hub_pin_partner #(
   parameter NPORT = 7
) (
   input  wire logic             ref_clk,
   input  wire logic [NPORT-1:0] ocFault,
   input  wire logic [NPORT-1:0] portPowerOe_r,
   input  wire logic [NPORT-1:0] portPullupEn_r,
   input  wire logic             sharedPowerOe_r,
   input  wire logic             sharedPullupEn_r,
   input  wire logic             romChipSelN_r,
   input  wire logic             romClkOut_r,
   input  wire logic             romClkOe_r,
   output wire logic [NPORT-1:0] portPowerSensePin,
   output wire logic             sharedPowerPin,
   output wire logic             romClkPin,
   output wire logic             romDataInPin
);
   logic tog = 1'b0;
   logic romBit = 1'b0;
   always @(posedge ref_clk) tog <= ~tog;
   always @(posedge romClkOut_r) romBit <= ~romBit;
   // A released pin without pull-up wanders each cycle.
   assign portPowerSensePin = ~portPowerOe_r & ~ocFault & (portPullupEn_r | {NPORT{tog}});
   assign sharedPowerPin = ~sharedPowerOe_r & (sharedPullupEn_r | tog);
   assign romClkPin = romClkOe_r ? romClkOut_r : 1'b0;
   assign romDataInPin = romChipSelN_r ? 1'b1 : romBit;
endmodule

// ===== testbench/hub_port_power_role_ctrl_test.sv
`timescale 1ns/1ps
`include "hub_port_ctrl_regs.vh"
module hub_port_power_role_ctrl_test;
   logic        ref_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, roleSwapRequest = 1'b0;
   logic        romEngChipSelN = 1'b1, romEngClk = 1'b0, romEngDataOut = 1'b0;
   logic [3:0]  typecAttachIn = 4'h0;
   logic [6:0]  ocFault = 7'h00;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_r;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [31:0]  s_axi_rdata;
   wire [6:0]   portPowerSensePin, portPowerOut_r, portPowerOe_r, portPullupEn_r;
   wire         sharedPowerPin, sharedPowerOut_r, sharedPowerOe_r, sharedPullupEn_r;
   wire         roleSwapIndicator_r, port0Upstream_r, port1Upstream_r, romEngDataIn_r;
   wire [3:0]   phyPowerOn_r;
   wire         romChipSelN_r, romClkPin, romClkOut_r, romClkOe_r, romDataOut_r, romDataOe_r, romDataInPin;
   int          n_fail = 0;
   int          checked = 0;
   logic [31:0] d;

   hub_port_power_role_ctrl #(.NPORT(7), .NATTACH(4)) DUT (.*);
   hub_pin_partner #(.NPORT(7)) partner (.*);

   // ----------------------------------------------------------------
   // Bus and compare tasks.
   // ----------------------------------------------------------------
   task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task wr(input [7:0] a, input [31:0] v, input [1:0] e);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", s_axi_bresp, e);
   endtask
   task rd(input [7:0] a, input [1:0] e);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      chk("rresp", s_axi_rresp, e);
   endtask

   // ----------------------------------------------------------------
   // Scenarios.
   // ----------------------------------------------------------------
   task t_regs;
      rd(`OFS_CTRL, `RESP_OKAY);
      chk("ctrl", d, 32'h0);
      rd(`OFS_PORT_CFG_EN, `RESP_OKAY);
      chk("cfg en", d, 32'h7F);
      rd(`OFS_PORT_HOST, `RESP_OKAY);
      chk("host en", d, 32'h7F);
      rd(`OFS_INT_MASK, `RESP_OKAY);
      chk("mask", d, 32'h0);
      rd(8'h1C, `RESP_SLVERR);
      chk("unmapped", d, 32'h0);
      wr(8'h1C, 32'hFFFF_FFFF, `RESP_SLVERR);
      wr(`OFS_STATUS, 32'hFFFF_FFFF, `RESP_OKAY);
      $display("t_regs done");
   endtask
   task t_ports;
      chk("pullup", portPullupEn_r, 7'h7F);
      chk("oe", portPowerOe_r, 7'h00);
      wr(`OFS_PORT_CFG_EN, 32'h7B, `RESP_OKAY);
      wr(`OFS_PORT_HOST, 32'h5F, `RESP_OKAY);
      cyc(2);
      chk("oe", portPowerOe_r, 7'h24);
      chk("pullup", portPullupEn_r, 7'h5B);
      chk("drive", portPowerOut_r, 7'h00);
      wr(`OFS_PORT_HOST, 32'h7F, `RESP_OKAY);
      $display("t_ports done");
   endtask
   task t_irq;
      wr(`OFS_INT_STAT, 32'hFFF, `RESP_OKAY);
      ocFault <= 7'h0C;
      cyc(4);
      rd(`OFS_STATUS, `RESP_OKAY);
      chk("overcurrent", d[6:0], 7'h08);
      chk("irq masked", irq_r, 1'h0);
      wr(`OFS_INT_MASK, 32'h8, `RESP_OKAY);
      cyc(2);
      chk("irq on", irq_r, 1'h1);
      wr(`OFS_INT_STAT, 32'h8, `RESP_OKAY);
      cyc(2);
      chk("irq cleared", irq_r, 1'h0);
      ocFault <= 7'h00;
      wr(`OFS_INT_MASK, 32'h0, `RESP_OKAY);
      wr(`OFS_PORT_CFG_EN, 32'h7F, `RESP_OKAY);
      $display("t_irq done");
   endtask
   task t_gang;
      wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
      cyc(2);
      chk("gang oe", portPowerOe_r, 7'h00);
      chk("gang pullup", portPullupEn_r, 7'h00);
      chk("shared pullup", sharedPullupEn_r, 1'h1);
      chk("shared out", sharedPowerOut_r, 1'h0);
      wr(`OFS_PORT_CFG_EN, 32'h0, `RESP_OKAY);
      cyc(2);
      chk("shared oe", sharedPowerOe_r, 1'h1);
      wr(`OFS_PORT_CFG_EN, 32'h7F, `RESP_OKAY);
      wr(`OFS_CTRL, 32'h0, `RESP_OKAY);
      cyc(2);
      chk("ungang", portPullupEn_r, 7'h7F);
      $display("t_gang done");
   endtask
   task t_role;
      for (int v = 1; v >= 0; v--) begin
         @(posedge ref_clk);
         roleSwapRequest <= v[0];
         cyc(4);
         chk("indicator", roleSwapIndicator_r, v);
         chk("port1 up", port1Upstream_r, v);
         chk("port0 up", port0Upstream_r, !v);
         rd(`OFS_STATUS, `RESP_OKAY);
         chk("status role", d[`ST_ROLE], v);
      end
      $display("t_role done");
   endtask
   task t_phy;
      for (int i = 0; i < 16; i++) begin
         @(posedge ref_clk);
         typecAttachIn <= i[3:0];
         cyc(4);
         chk("phy power", phyPowerOn_r, i);
      end
      chk("phy all on", phyPowerOn_r, 4'hF);
      $display("t_phy done");
   endtask
   task t_rom;
      @(posedge ref_clk);
      romEngChipSelN <= 1'b0;
      romEngDataOut <= 1'b1;
      romEngClk <= 1'b1;
      cyc(3);
      chk("cs", romChipSelN_r, 1'h0);
      chk("data out", romDataOut_r, 1'h1);
      chk("data oe on", romDataOe_r, 1'h1);
      chk("data in on", romEngDataIn_r, 1'h1);
      chk("rom clk", romClkOut_r, 1'h1);
      wr(`OFS_CTRL, 32'h4, `RESP_OKAY);
      cyc(2);
      chk("cs down", romChipSelN_r, 1'h1);
      wr(`OFS_CTRL, 32'h2, `RESP_OKAY);
      wr(`OFS_SPARE_IO, 32'h3, `RESP_OKAY);
      cyc(4);
      chk("spare oe", romClkOe_r, 1'h1);
      chk("spare out", romClkOut_r, 1'h1);
      chk("data oe", romDataOe_r, 1'h0);
      chk("data in", romEngDataIn_r, 1'h0);
      rd(`OFS_STATUS, `RESP_OKAY);
      chk("spare in", d[`ST_SPARE_IN], 1'h1);
      wr(`OFS_SPARE_IO, 32'h1, `RESP_OKAY);
      cyc(4);
      rd(`OFS_STATUS, `RESP_OKAY);
      chk("spare in low", d[`ST_SPARE_IN], 1'h0);
      wr(`OFS_CTRL, 32'h0, `RESP_OKAY);
      romEngChipSelN <= 1'b1;
      $display("t_rom done");
   endtask

   // ----------------------------------------------------------------
   // Run control.
   // ----------------------------------------------------------------
   task finish_test;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      #500000;
      n_fail++;
      $display("watchdog expired");
      finish_test;
   end
   initial begin
      cyc(8);
      chk("clk in reset", {romClkOe_r, romClkOut_r}, 2'h2);
      rst_n <= 1'b1;
      cyc(2);
      t_regs;
      t_ports;
      t_irq;
      t_gang;
      t_role;
      t_phy;
      t_rom;
      finish_test;
   end
endmodule
